//--- bench/occ_clk_ctrl_props.sv
// occ_clk_ctrl_props: port checker for occ_clk_ctrl.
// assumes ce_in is held high.
`timescale 1ns/1ps
`default_nettype none
module occ_clk_ctrl_props #(
   parameter int NGEN = 4
) (
   // clock, reset, sleep
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic standby_in,
   // requests and writes
   input wire logic [3:0] periph_req_in,
   input wire occ_pkg::occ_src_cfg_t src_cfg_in,
   input wire logic [3:0] src_wr_in,
   input wire occ_pkg::occ_gen_cfg_t gen_cfg_in,
   input wire logic [NGEN-1:0] gen_wr_in,
   // outputs
   input wire logic [3:0] osc_en_out,
   input wire logic [3:0] osc_rdy_out,
   input wire logic [1:0] lock_out,
   input wire logic [NGEN-1:0] gclk_out,
   input wire logic [NGEN-1:0] gclk_pin_oe_n_out
);
   logic [3:0] rs_q;
   // shadow of run-in-standby; locked writes in the bench keep this bit
   always_ff @(posedge core_clk_in) begin
      for (int i = 0; i < 4; i++) begin
         rs_q[i] <= !rst_n_in ? 1'b0 : src_wr_in[i] ? src_cfg_in.run_stby : rs_q[i];
      end
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   od_ext32_a: assert property ($rose(osc_en_out[1]) |-> $past(periph_req_in[1]))
      else $error("ext 32k started unrequested");
   od_hf_a: assert property ($rose(osc_en_out[0]) |-> $past(periph_req_in[0]))
      else $error("hf started unrequested");
   od_8m_a: assert property ($rose(osc_en_out[3]) |-> $past(periph_req_in[3]))
      else $error("8m started unrequested");
   stby_stop_a: assert property ((standby_in && !rs_q[3]) [*3] |-> !osc_en_out[3])
      else $error("8m kept running in standby");
   stby_keep_a: assert property (standby_in && rs_q[0] && periph_req_in[0] && osc_en_out[0]
      |=> osc_en_out[0]) else $error("hf stopped in standby");
   rdy_late_a: assert property ($rose(osc_rdy_out[0]) |-> $past(osc_en_out[0]))
      else $error("ready without start-up");
   lock_set_a: assert property (src_wr_in[1] && src_cfg_in.write_once |-> ##2 lock_out[0])
      else $error("lock not set");
   lock_hold_a: assert property (lock_out[1] |=> lock_out[1])
      else $error("lock released");
   gen_idle_a: assert property (gen_wr_in[0] && !gen_cfg_in.enable ##1 !gen_wr_in[0]
      |=> gclk_out[0] == $past(gen_cfg_in.high_idle, 2)) else $error("idle level");
   pin_oe_a: assert property (gen_wr_in[0] ##1 !gen_wr_in[0]
      |=> gclk_pin_oe_n_out[0] == !$past(gen_cfg_in.pin_en, 2)) else $error("pin enable");
   cover property ($rose(osc_rdy_out[0]));
   cover property ($rose(lock_out[1]));
   cover property (standby_in && $rose(gclk_out[0]));
endmodule : occ_clk_ctrl_props
bind occ_clk_ctrl occ_clk_ctrl_props #(.NGEN(NGEN)) u_props (
   .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .standby_in(standby_in),
   .periph_req_in(periph_req_in), .src_cfg_in(src_cfg_in), .src_wr_in(src_wr_in),
   .gen_cfg_in(gen_cfg_in), .gen_wr_in(gen_wr_in), .osc_en_out(osc_en_out),
   .osc_rdy_out(osc_rdy_out), .lock_out(lock_out), .gclk_out(gclk_out),
   .gclk_pin_oe_n_out(gclk_pin_oe_n_out));
`default_nettype wire

//--- bench/occ_clk_ctrl_tb_top.sv
// occ_clk_ctrl_tb_top: self-checking bench for the clock control block.
// assumes occ_osc_model drives the oscillator levels.
`timescale 1ns/1ps
`default_nettype none
module occ_clk_ctrl_tb_top;
   logic core_clk_in, rst_n_in, standby_in, e32, e1, i32, i1, i8;
   logic [3:0] req, src_wr, osc_en, osc_rdy, lvl, gen_wr, gclk, oe_n, gpin;
   logic [1:0] agc, lock, xtal;
   logic [5:0] pv;
   occ_pkg::occ_src_cfg_t src_cfg;
   occ_pkg::occ_gen_cfg_t gen_cfg;
   int error_cnt = 0;
   int checked = 0;
   int p;
   // source periods: osc 3 cycles, 1k is /32, 8m prescaled /8
   int sp [6] = '{3, 3, 96, 3, 96, 24};
   wire logic [5:0] sig = {gclk[0], i8, i1, i32, e1, e32};
   wire logic [5:0] rs = sig & ~pv;
   initial begin
      core_clk_in = 1'b0;
      forever #2.5 core_clk_in = ~core_clk_in;
   end
   always @(posedge core_clk_in) pv <= sig;
   occ_osc_model u_osc (.clk_in(core_clk_in), .rst_n_in(rst_n_in), .en_in(osc_en), .lvl_out(lvl));
   occ_clk_ctrl #(.NGEN(4)) u_dut (
      .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .standby_in(standby_in),
      .osc_lvl_in(lvl), .periph_req_in(req), .src_cfg_in(src_cfg), .src_wr_in(src_wr),
      .gen_cfg_in(gen_cfg), .gen_wr_in(gen_wr), .osc_en_out(osc_en), .osc_rdy_out(osc_rdy),
      .xtal_en_out(xtal), .agc_en_out(agc), .lock_out(lock), .ext_32k_out(e32), .ext_1k_out(e1),
      .int_32k_out(i32), .int_1k_out(i1), .int_8m_out(i8), .gclk_out(gclk),
      .gclk_pin_out(gpin), .gclk_pin_oe_n_out(oe_n));
   task chk(input logic c, input string m);
      checked++;
      if (c !== 1'b1) begin
         error_cnt++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask : cyc
   function automatic occ_pkg::occ_src_cfg_t sc(input logic r, w, a, k1, k32,
                                               input logic [15:0] st);
      sc = '{1'b1, 1'b1, r, w, 1'b1, a, k1, k32, 2'h0, st};
   endfunction : sc
   task wsrc(input int k, input occ_pkg::occ_src_cfg_t c);
      @(posedge core_clk_in);
      src_cfg <= c;
      src_wr <= 4'h1 << k;
      @(posedge core_clk_in);
      src_wr <= 4'h0;
   endtask : wsrc
   task wgen(input int g, input occ_pkg::occ_gen_cfg_t c);
      @(posedge core_clk_in);
      gen_cfg <= c;
      gen_wr <= 4'h1 << g;
      @(posedge core_clk_in);
      gen_wr <= 4'h0;
   endtask : wgen
   task wrdy(input logic [3:0] m);
      int n;
      n = 0;
      while ((osc_rdy & m) !== m && n < 2000) begin
         cyc(1);
         n++;
      end
      chk(n < 2000, "ready timeout");
   endtask : wrdy
   // counts oscillator pulses from request to ready; each pulse is one cycle wide
   task stup(input int k, input int exp);
      int n;
      int t;
      n = 0;
      t = 0;
      @(posedge core_clk_in);
      req[k] <= 1'b1;
      while (osc_rdy[k] !== 1'b1 && t < 60000) begin
         cyc(1);
         t++;
         if (lvl[k] === 1'b1) n++;
      end
      chk(n == exp, "start-up count");
   endtask : stup
   // skips two rises so a config change has settled, then times one period
   task per(input int b, output int q);
      int n;
      n = 0;
      q = 0;
      repeat (2) begin
         do begin
            cyc(1);
            n++;
         end while (rs[b] !== 1'b1 && n < 900);
      end
      do begin
         cyc(1);
         q++;
      end while (rs[b] !== 1'b1 && q < 500);
   endtask : per
   task do_reset;
      @(posedge core_clk_in);
      rst_n_in <= 1'b0;
      req <= 4'h0;
      repeat (3) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      cyc(1);
   endtask : do_reset
   task t_start;
      cyc(20);
      chk(osc_en === 4'h0, "unrequested start");
      stup(2, 130);
      stup(0, 16384);
      chk(agc[0] === 1'b1, "gain control off");
      per(2, p);
      chk(p == 3, "int 32k period");
      per(3, p);
      chk(p == 96, "int 1k period");
      stup(3, 1);
      per(4, p);
      chk(p == 24, "8m prescale");
   endtask : t_start
   task t_lock;
      wsrc(1, sc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0004));
      cyc(2);
      chk(lock[0] === 1'b1, "ext lock");
      wsrc(1, sc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0004));
      wsrc(2, sc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0082));
      cyc(2);
      chk(lock[1] === 1'b1, "int lock");
      wsrc(2, sc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0082));
      @(posedge core_clk_in);
      req[1] <= 1'b1;
      wrdy(4'h2);
      per(1, p);
      chk(p == 96, "ext 1k period");
      per(0, p);
      chk(p == 3, "ext 32k period");
      per(2, p);
      chk(p == 3, "int 32k period");
      do_reset();
      chk(lock === 2'h0, "lock after reset");
   endtask : t_lock
   task t_stby;
      wsrc(0, sc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0004));
      // peripheral request first, so the start is not owed to a generator
      @(posedge core_clk_in);
      req <= 4'h9;
      wgen(0, '{1'b1, 1'b0, 1'b1, 1'b1, 3'h0, 16'h0001});
      wgen(1, '{1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 16'h0002});
      wrdy(4'h9);
      chk(agc[0] === 1'b0, "gain control on");
      chk(xtal === 2'b01, "crystal driver");
      chk(oe_n[1:0] === 2'b10, "pin enable");
      @(posedge core_clk_in);
      standby_in <= 1'b1;
      cyc(4);
      chk(osc_en === 4'h1, "standby run");
      chk(gclk[1] === 1'b1, "stopped generator level");
      per(5, p);
      chk(p == 3, "generator in standby");
      @(posedge core_clk_in);
      standby_in <= 1'b0;
      cyc(2);
      chk(osc_rdy[3] === 1'b0, "no restart delay");
      wrdy(4'h8);
      do_reset();
   endtask : t_stby
   task t_gen;
      wsrc(0, sc(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0004));
      wsrc(1, sc(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0004));
      @(posedge core_clk_in);
      req <= 4'hF;
      wrdy(4'hF);
      for (int s = 0; s < 6; s++) begin
         wgen(0, '{1'b1, 1'b0, 1'b1, 1'b0, s[2:0], 16'h0002});
         per(5, p);
         chk(p == 2 * sp[s], "divided period");
      end
      wgen(0, '{1'b1, 1'b0, 1'b1, 1'b0, 3'h5, 16'h0003});
      per(5, p);
      chk(p == 72, "divide by 3");
      wgen(0, '{1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 16'h0001});
      cyc(2);
      chk(gclk[0] === 1'b1 && oe_n[0] === 1'b1, "idle high");
      chk(gpin[0] === 1'b1, "pin idle high");
      wgen(0, '{1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 16'h0001});
      cyc(2);
      chk(gclk[0] === 1'b0, "idle low");
      chk(gpin[0] === 1'b0, "pin idle low");
   endtask : t_gen
   task end_sim;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      rst_n_in = 1'b0;
      standby_in = 1'b0;
      req = 4'h0;
      src_wr = 4'h0;
      gen_wr = 4'h0;
      src_cfg = '0;
      gen_cfg = '0;
      repeat (3) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      t_start();
      t_lock();
      t_stby();
      t_gen();
      end_sim();
   end
   // about 60000 cycles are expected; twice that means a hang
   initial begin
      #600000;
      error_cnt++;
      end_sim();
   end
endmodule : occ_clk_ctrl_tb_top
`default_nettype wire

//--- bench/occ_osc_model.sv
// occ_osc_model: the four oscillators, one short pulse every 3 core cycles.
// assumes en_in comes from the block's oscillator enables.
`timescale 1ns/1ps
`default_nettype none
module occ_osc_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // enables and levels
   input wire logic [3:0] en_in,
   output logic [3:0] lvl_out
);
   logic [1:0] ph_q [4];
   // a stopped oscillator stands still low, so no stray edge can be counted
   always_ff @(posedge clk_in) begin
      for (int i = 0; i < 4; i++) begin
         ph_q[i] <= (!rst_n_in || !en_in[i] || ph_q[i] == 2'h2) ? 2'h0 : ph_q[i] + 2'h1;
      end
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lvl_out[i] = en_in[i] && ph_q[i] == 2'h1;
      end
   end
endmodule : occ_osc_model
`default_nettype wire

//--- rtl/occ_clk_ctrl.sv
// occ_clk_ctrl: oscillator configuration, run control and generic clock generators.
// assumes oscillator levels and all control ports are synchronous to core_clk_in.
`timescale 1ns/1ps
`default_nettype none
module occ_clk_ctrl #(
   parameter int NGEN = 4
) (
   // clock, reset, enable
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // sleep
   input wire logic standby_in,
   // oscillator clock levels: ext hf, ext 32k, int 32k, int 8m
   input wire logic [occ_pkg::OCC_NOSC-1:0] osc_lvl_in,
   // peripheral clock requests, one per oscillator
   input wire logic [occ_pkg::OCC_NOSC-1:0] periph_req_in,
   // source configuration writes
   input wire occ_pkg::occ_src_cfg_t src_cfg_in,
   input wire logic [occ_pkg::OCC_NOSC-1:0] src_wr_in,
   // generator configuration writes
   input wire occ_pkg::occ_gen_cfg_t gen_cfg_in,
   input wire logic [NGEN-1:0] gen_wr_in,
   // oscillator state
   output logic [occ_pkg::OCC_NOSC-1:0] osc_en_out,
   output logic [occ_pkg::OCC_NOSC-1:0] osc_rdy_out,
   output logic [1:0] xtal_en_out,
   output logic [1:0] agc_en_out,
   output logic [1:0] lock_out,
   // source clock outputs
   output logic ext_32k_out,
   output logic ext_1k_out,
   output logic int_32k_out,
   output logic int_1k_out,
   output logic int_8m_out,
   // generators
   output logic [NGEN-1:0] gclk_out,
   output logic [NGEN-1:0] gclk_pin_out,
   output logic [NGEN-1:0] gclk_pin_oe_n_out
);
   localparam int HF = occ_pkg::OCC_OSC_EXT_HF;
   localparam int E32 = occ_pkg::OCC_OSC_EXT_CRYSTAL_OSC_32K;
   localparam int I32 = occ_pkg::OCC_OSC_INT_RC_OSC_32K;
   localparam int I8 = occ_pkg::OCC_OSC_INT_RC_OSC_8M;
   localparam int K1_MSB = occ_pkg::OCC_K1_W - 1;

   occ_pkg::occ_src_cfg_t src_q [occ_pkg::OCC_NOSC];
   occ_pkg::occ_gen_cfg_t gen_q [NGEN];
   logic lock_e32_q;
   logic lock_i32_q;
   logic [occ_pkg::OCC_NOSC-1:0] lvl_prev_q;
   logic [occ_pkg::OCC_NSRC-1:0] src_prev_q;
   logic [occ_pkg::OCC_K1_W-1:0] e32_div_q;
   logic [occ_pkg::OCC_K1_W-1:0] i32_div_q;
   logic [occ_pkg::OCC_P8_W-1:0] p8_q;

   logic [occ_pkg::OCC_NOSC-1:0] raw_tick;
   logic [occ_pkg::OCC_NOSC-1:0] osc_req;
   logic [occ_pkg::OCC_NOSC-1:0] osc_en;
   logic [occ_pkg::OCC_NOSC-1:0] osc_rdy;
   logic [occ_pkg::OCC_NSRC-1:0] src_lvl;
   logic [occ_pkg::OCC_NSRC-1:0] src_tick;
   logic [NGEN-1:0] gen_req;
   logic [NGEN-1:0] gen_lvl;
   logic [NGEN-1:0] gen_tick;
   logic [NGEN-1:0] gen_clk;
   logic [NGEN-1:0] gen_pin;
   logic [NGEN-1:0] gen_pin_oe_n;
   logic lvl_8m_div;
   logic wr_e32_ok;
   logic wr_i32_ok;

   // prescaled 8m level from the divide chain
   function automatic logic occ_presc_lvl(input logic raw,
                                          input logic [occ_pkg::OCC_P8_W-1:0] chain,
                                          input logic [occ_pkg::OCC_PRE_W-1:0] presc);
      if (presc == '0) begin
         occ_presc_lvl = raw;
      end else begin
         occ_presc_lvl = chain[presc - 1'b1];
      end
   endfunction : occ_presc_lvl

   // indexed source select, unused codes read low
   function automatic logic occ_pick(input logic [occ_pkg::OCC_NSRC-1:0] vec,
                                     input logic [occ_pkg::OCC_SEL_W-1:0] sel);
      if (sel > occ_pkg::OCC_SRC_INT_8M) begin
         occ_pick = 1'b0;
      end else begin
         occ_pick = vec[sel];
      end
   endfunction : occ_pick

   // locked writes are dropped silently
   assign wr_e32_ok = src_wr_in[E32] & ~lock_e32_q;
   assign wr_i32_ok = src_wr_in[I32] & ~lock_i32_q;

   assign raw_tick = osc_lvl_in & ~lvl_prev_q;
   assign lvl_8m_div = occ_presc_lvl(osc_lvl_in[I8], p8_q, src_q[I8].presc);

   // gated source levels, only once the oscillator is ready
   assign src_lvl[occ_pkg::OCC_SRC_EXT_HF] = osc_lvl_in[HF] & osc_rdy[HF];
   assign src_lvl[occ_pkg::OCC_SRC_EXT_32K] =
      osc_lvl_in[E32] & osc_rdy[E32] & src_q[E32].en_32k;
   assign src_lvl[occ_pkg::OCC_SRC_EXT_1K] =
      e32_div_q[K1_MSB] & osc_rdy[E32] & src_q[E32].en_1k;
   assign src_lvl[occ_pkg::OCC_SRC_INT_32K] =
      osc_lvl_in[I32] & osc_rdy[I32] & src_q[I32].en_32k;
   assign src_lvl[occ_pkg::OCC_SRC_INT_1K] =
      i32_div_q[K1_MSB] & osc_rdy[I32] & src_q[I32].en_1k;
   assign src_lvl[occ_pkg::OCC_SRC_INT_8M] = lvl_8m_div & osc_rdy[I8];
   assign src_tick = src_lvl & ~src_prev_q;

   // requests from peripherals and from generators using each oscillator
   always_comb begin
      osc_req = periph_req_in;
      for (int g = 0; g < NGEN; g++) begin
         if (gen_req[g]) begin
            osc_req[occ_pkg::occ_src_osc(gen_q[g].src_sel)] = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         src_q[HF] <= occ_pkg::OCC_RST_EXT_HF;
         src_q[E32] <= occ_pkg::OCC_RST_EXT_32K;
         src_q[I32] <= occ_pkg::OCC_RST_INT_32K;
         src_q[I8] <= occ_pkg::OCC_RST_INT_8M;
         lock_e32_q <= 1'b0;
         lock_i32_q <= 1'b0;
      end else if (ce_in) begin
         if (src_wr_in[HF]) begin
            src_q[HF] <= src_cfg_in;
         end
         if (src_wr_in[I8]) begin
            src_q[I8] <= src_cfg_in;
         end
         if (wr_e32_ok) begin
            src_q[E32] <= src_cfg_in;
            lock_e32_q <= src_cfg_in.write_once;
         end
         if (wr_i32_ok) begin
            src_q[I32] <= src_cfg_in;
            lock_i32_q <= src_cfg_in.write_once;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         for (int g = 0; g < NGEN; g++) begin
            gen_q[g] <= occ_pkg::OCC_RST_GEN;
         end
      end else if (ce_in) begin
         for (int g = 0; g < NGEN; g++) begin
            if (gen_wr_in[g]) begin
               gen_q[g] <= gen_cfg_in;
            end
         end
      end
   end

   // 1k outputs divide the 32k clocks by 32; 8m chain divides by up to 8
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         lvl_prev_q <= '0;
         src_prev_q <= '0;
         e32_div_q <= '0;
         i32_div_q <= '0;
         p8_q <= '0;
      end else if (ce_in) begin
         lvl_prev_q <= osc_lvl_in;
         src_prev_q <= src_lvl;
         if (!osc_rdy[E32]) begin
            e32_div_q <= '0;
         end else if (raw_tick[E32]) begin
            e32_div_q <= e32_div_q + 1'b1;
         end
         if (!osc_rdy[I32]) begin
            i32_div_q <= '0;
         end else if (raw_tick[I32]) begin
            i32_div_q <= i32_div_q + 1'b1;
         end
         if (!osc_rdy[I8]) begin
            p8_q <= '0;
         end else if (raw_tick[I8]) begin
            p8_q <= p8_q + 1'b1;
         end
      end
   end

   // registered oscillator-side outputs
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         xtal_en_out <= '0;
         agc_en_out <= '0;
         lock_out <= '0;
         ext_32k_out <= 1'b0;
         ext_1k_out <= 1'b0;
         int_32k_out <= 1'b0;
         int_1k_out <= 1'b0;
         int_8m_out <= 1'b0;
      end else if (ce_in) begin
         // gain control only matters while a crystal is actually driven
         xtal_en_out[0] <= osc_en[HF] & src_q[HF].crystal;
         xtal_en_out[1] <= osc_en[E32] & src_q[E32].crystal;
         agc_en_out[0] <= osc_en[HF] & src_q[HF].crystal & src_q[HF].auto_gain;
         agc_en_out[1] <= osc_en[E32] & src_q[E32].crystal & src_q[E32].auto_gain;
         lock_out <= {lock_i32_q, lock_e32_q};
         ext_32k_out <= src_lvl[occ_pkg::OCC_SRC_EXT_32K];
         ext_1k_out <= src_lvl[occ_pkg::OCC_SRC_EXT_1K];
         int_32k_out <= src_lvl[occ_pkg::OCC_SRC_INT_32K];
         int_1k_out <= src_lvl[occ_pkg::OCC_SRC_INT_1K];
         int_8m_out <= src_lvl[occ_pkg::OCC_SRC_INT_8M];
      end
   end

   for (genvar i = 0; i < occ_pkg::OCC_NOSC; i++) begin : g_osc
      occ_src_ctl #(
         .STUP_W(occ_pkg::OCC_STUP_W)
      ) u_ctl (
         .clk_in(core_clk_in),
         .rst_n_in(rst_n_in),
         .ce_in(ce_in),
         .enable_in(src_q[i].enable),
         .on_demand_in(src_q[i].on_demand),
         .run_stby_in(src_q[i].run_stby),
         .req_in(osc_req[i]),
         .standby_in(standby_in),
         .tick_in(raw_tick[i]),
         .startup_in(src_q[i].startup),
         .osc_en_out(osc_en[i]),
         .ready_out(osc_rdy[i])
      );
   end

   for (genvar g = 0; g < NGEN; g++) begin : g_gen
      assign gen_lvl[g] = occ_pick(src_lvl, gen_q[g].src_sel);
      assign gen_tick[g] = occ_pick(src_tick, gen_q[g].src_sel);
      occ_gclk_gen #(
         .DIV_W(occ_pkg::OCC_DIV_W)
      ) u_gen (
         .clk_in(core_clk_in),
         .rst_n_in(rst_n_in),
         .ce_in(ce_in),
         .cfg_in(gen_q[g]),
         .standby_in(standby_in),
         .src_lvl_in(gen_lvl[g]),
         .src_tick_in(gen_tick[g]),
         .clk_out(gen_clk[g]),
         .pin_out(gen_pin[g]),
         .pin_oe_n_out(gen_pin_oe_n[g]),
         .req_out(gen_req[g])
      );
   end

   // these are flop outputs of the sub-blocks
   assign osc_en_out = osc_en;
   assign osc_rdy_out = osc_rdy;
   assign gclk_out = gen_clk;
   assign gclk_pin_out = gen_pin;
   assign gclk_pin_oe_n_out = gen_pin_oe_n;
endmodule : occ_clk_ctrl
`default_nettype wire

//--- rtl/occ_gclk_gen.sv
// occ_gclk_gen: one generic clock generator, divider and idle level.
// assumes the selected source level and its rising-edge tick come from the top.
`timescale 1ns/1ps
`default_nettype none
module occ_gclk_gen #(
   parameter int DIV_W = occ_pkg::OCC_DIV_W
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // configuration and sleep
   input wire occ_pkg::occ_gen_cfg_t cfg_in,
   input wire logic standby_in,
   // selected source
   input wire logic src_lvl_in,
   input wire logic src_tick_in,
   // outputs
   output logic clk_out,
   output logic pin_out,
   output logic pin_oe_n_out,
   output logic req_out
);
   logic [DIV_W-1:0] cnt_q;
   logic active;
   logic divided;
   logic wrap;

   assign active = cfg_in.enable & (~standby_in | cfg_in.run_stby);
   assign wrap = (cnt_q + 1'b1) >= cfg_in.div;
   // factor 0 or 1 passes the source; others high for the first half
   assign divided = (cfg_in.div <= DIV_W'(1)) ? src_lvl_in : (cnt_q < (cfg_in.div >> 1));

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cnt_q <= '0;
         clk_out <= 1'b0;
         pin_out <= 1'b0;
         pin_oe_n_out <= 1'b1;
         req_out <= 1'b0;
      end else if (ce_in) begin
         if (!active) begin
            cnt_q <= '0;
         end else if (src_tick_in) begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
         end
         clk_out <= active ? divided : cfg_in.high_idle;
         pin_out <= active ? divided : cfg_in.high_idle;
         pin_oe_n_out <= ~cfg_in.pin_en;
         req_out <= active;
      end
   end
endmodule : occ_gclk_gen
`default_nettype wire

//--- rtl/occ_pkg.sv
// occ_pkg: shared types, indices and reset values of the oscillator and clock generator control.
// assumes one core clock; all oscillator levels arrive already synchronous to it.
package occ_pkg;
   localparam int OCC_NOSC = 4;
   localparam int OCC_NSRC = 6;
   localparam int OCC_STUP_W = 16;
   localparam int OCC_DIV_W = 16;
   localparam int OCC_SEL_W = 3;
   localparam int OCC_PRE_W = 2;
   localparam int OCC_K1_W = 5;
   localparam int OCC_P8_W = 3;

   // oscillator indices
   localparam int OCC_OSC_EXT_HF = 0;
   localparam int OCC_OSC_EXT_CRYSTAL_OSC_32K = 1;
   localparam int OCC_OSC_INT_RC_OSC_32K = 2;
   localparam int OCC_OSC_INT_RC_OSC_8M = 3;

   // generator source indices
   localparam logic [2:0] OCC_SRC_EXT_HF = 3'h0;
   localparam logic [2:0] OCC_SRC_EXT_32K = 3'h1;
   localparam logic [2:0] OCC_SRC_EXT_1K = 3'h2;
   localparam logic [2:0] OCC_SRC_INT_32K = 3'h3;
   localparam logic [2:0] OCC_SRC_INT_1K = 3'h4;
   localparam logic [2:0] OCC_SRC_INT_8M = 3'h5;

   localparam logic [15:0] OCC_STUP_EXT = 16'h4000;
   localparam logic [15:0] OCC_STUP_INT32 = 16'h0082;
   localparam logic [15:0] OCC_STUP_INT8 = 16'h0001;
   localparam logic [1:0] OCC_PRE_DIV8 = 2'h3;
   localparam logic [15:0] OCC_DIV_RST = 16'h0001;

   typedef struct packed {
      logic enable;
      logic on_demand;
      logic run_stby;
      logic write_once;
      logic crystal;
      logic auto_gain;
      logic en_1k;
      logic en_32k;
      logic [OCC_PRE_W-1:0] presc;
      logic [OCC_STUP_W-1:0] startup;
   } occ_src_cfg_t;

   typedef struct packed {
      logic enable;
      logic high_idle;
      logic pin_en;
      logic run_stby;
      logic [OCC_SEL_W-1:0] src_sel;
      logic [OCC_DIV_W-1:0] div;
   } occ_gen_cfg_t;

   localparam occ_src_cfg_t OCC_RST_EXT_HF =
      '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0, OCC_STUP_EXT};
   localparam occ_src_cfg_t OCC_RST_EXT_32K =
      '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0, OCC_STUP_EXT};
   localparam occ_src_cfg_t OCC_RST_INT_32K =
      '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 2'h0, OCC_STUP_INT32};
   localparam occ_src_cfg_t OCC_RST_INT_8M =
      '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, OCC_PRE_DIV8, OCC_STUP_INT8};
   localparam occ_gen_cfg_t OCC_RST_GEN =
      '{1'b0, 1'b0, 1'b0, 1'b0, OCC_SRC_EXT_HF, OCC_DIV_RST};

   typedef enum logic [2:0] {
      OCC_ST_OFF = 3'b001,
      OCC_ST_START = 3'b010,
      OCC_ST_RUN = 3'b100
   } occ_osc_st_t;

   // generator source index to the oscillator behind it
   function automatic logic [1:0] occ_src_osc(input logic [OCC_SEL_W-1:0] sel);
      unique case (sel)
         OCC_SRC_EXT_32K, OCC_SRC_EXT_1K: occ_src_osc = 2'h1;
         OCC_SRC_INT_32K, OCC_SRC_INT_1K: occ_src_osc = 2'h2;
         OCC_SRC_INT_8M: occ_src_osc = 2'h3;
         default: occ_src_osc = 2'h0;
      endcase
   endfunction : occ_src_osc
endpackage : occ_pkg

//--- rtl/occ_src_ctl.sv
// occ_src_ctl: run/start-up sequencing of one oscillator.
// assumes tick_in is a one-cycle pulse per oscillator input cycle.
`timescale 1ns/1ps
`default_nettype none
module occ_src_ctl #(
   parameter int STUP_W = occ_pkg::OCC_STUP_W
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // control
   input wire logic enable_in,
   input wire logic on_demand_in,
   input wire logic run_stby_in,
   input wire logic req_in,
   input wire logic standby_in,
   input wire logic tick_in,
   input wire logic [STUP_W-1:0] startup_in,
   // state
   output logic osc_en_out,
   output logic ready_out
);
   occ_pkg::occ_osc_st_t st_q;
   logic [STUP_W-1:0] cnt_q;
   logic want;
   logic done;

   assign want = enable_in & (~on_demand_in | req_in) & (~standby_in | run_stby_in);
   assign done = tick_in & ((cnt_q + 1'b1) >= startup_in);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_q <= occ_pkg::OCC_ST_OFF;
         cnt_q <= '0;
         osc_en_out <= 1'b0;
         ready_out <= 1'b0;
      end else if (ce_in) begin
         unique case (st_q)
            occ_pkg::OCC_ST_OFF: begin
               cnt_q <= '0;
               if (want) begin
                  st_q <= occ_pkg::OCC_ST_START;
                  osc_en_out <= 1'b1;
               end
            end
            occ_pkg::OCC_ST_START: begin
               if (!want) begin
                  st_q <= occ_pkg::OCC_ST_OFF;
                  osc_en_out <= 1'b0;
               end else if (done) begin
                  st_q <= occ_pkg::OCC_ST_RUN;
                  ready_out <= 1'b1;
               end else if (tick_in) begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            occ_pkg::OCC_ST_RUN: begin
               // restart always repeats the full start-up delay
               if (!want) begin
                  st_q <= occ_pkg::OCC_ST_OFF;
                  osc_en_out <= 1'b0;
                  ready_out <= 1'b0;
               end
            end
            default: begin
               st_q <= occ_pkg::OCC_ST_OFF;
               osc_en_out <= 1'b0;
               ready_out <= 1'b0;
            end
         endcase
      end
   end
endmodule : occ_src_ctl
`default_nettype wire
